/* File: src/ss_defs.svh */
// Register map, field positions, reset values and counts of the serial channel
`ifndef SS_DEFS_SVH
`define SS_DEFS_SVH

`define SS_OFF_CTRL   8'h60
`define SS_OFF_DATA   8'h64
`define SS_OFF_STAT   8'h68
`define SS_OFF_EXT    8'h6c
`define SS_OFF_FIFO   8'h70
`define SS_OFF_ISTAT  8'h74
`define SS_OFF_IMASK  8'h78

`define SS_CTL_CLEAR  15
`define SS_CTL_RIE    12
`define SS_CTL_TIE    11
`define SS_CTL_TRANSMIT_IDLE_IRQ_ENABLE   10
`define SS_CTL_RXE    9
`define SS_CTL_TXE    8

`define SS_ST_ERRCLR  15
`define SS_ST_ORE     11
`define SS_ST_RECEIVE_FULL_FLAG    10
`define SS_ST_TRANSMIT_EMPTY_FLAG    9
`define SS_ST_TBI     8

`define SS_EXT_FORCE  7
`define SS_FIFO_EN    0
`define SS_FIFO_THR   8
`define SS_FIFO_CNT   16

`define SS_EV_OVR     0
`define SS_EV_RXW     1
`define SS_EV_TXS     2
`define SS_EV_TIDLE   3

`define SS_RDR_RST    9'h000
`define SS_TDR_RST    9'h1ff
`define SS_LEN_RST    3'h0
`define SS_IDLE_BAUDS 4'h8

`endif

/* File: src/ss_pkg.sv */
// Types and length decoding shared by the serial channel
package ss_pkg;

    typedef enum logic [2:0] {
        SS_LEN8 = 3'b000,
        SS_LEN5 = 3'b001,
        SS_LEN6 = 3'b010,
        SS_LEN7 = 3'b011,
        SS_LEN9 = 3'b100
    } ss_len_e;

    // Prohibited codes fall back to 8 bits so the shifters never run away
    function automatic logic [3:0] ss_len_bits(input logic [2:0] code);
        logic [3:0] n;
        n = 4'h8;
        case (code)
            SS_LEN5: n = 4'h5;
            SS_LEN6: n = 4'h6;
            SS_LEN7: n = 4'h7;
            SS_LEN9: n = 4'h9;
            default: n = 4'h8;
        endcase
        return n;
    endfunction

    function automatic logic [8:0] ss_len_mask(input logic [2:0] code);
        logic [9:0] m;
        m = (10'h001 << ss_len_bits(code)) - 10'h001;
        return m[8:0];
    endfunction

endpackage

/* File: src/ss_sync_serial.sv */
// Status, length and data-register logic of one clock-synchronous serial channel
//
// Summary of operation
// R1 - Writing one to error_clear clears overrun_flag; zero ignored; reads zero.
// R2 - Overrun sets overrun_flag; data invalid; with receive enable it requests rx interrupt (the code gates rx_irq with receive_irq_enable instead).
// R3 - Overrun while receive FIFO used clears FIFO enable and stops storing.
// R4 - No FIFO: word load sets receive_full_flag, data read clears it.
// R5 - FIFO: flag sets at threshold count, clears when FIFO empties.
// R6 - Below threshold, 8 idle baud periods set flag; data read restarts count.
// R7 - Data write clears transmit_empty_flag; set when word enters shifter.
// R8 - Programmable clear forces transmit_empty_flag; flag with enable requests tx interrupt.
// R9 - Data write clears transmit_idle_flag; set when empty and not transmitting.
// R10 - output_force_high drives output high only while transmit disabled; reads zero.
// R11 - length_select: 000=8, 001=5, 010=6, 011=7, 100=9 bits.
// R12 - Receive data 9 bits read-only; bits above length read zero.
// R13 - Transmit data 9 bits write-only; upper bits ignored; shifted out when enabled.
// R14 - Data write refused while transmit empty flag zero and no FIFO room.
// R15 - Receive and transmit data share one address; reads receive, writes transmit.
// R16 - Software uses 16-bit accesses for 9-bit frames.
// R17 - Programmable clear resets internal state, aborts transfers, initialises flags.
// R18 - Dropping transmit or receive enable stops that transfer at once.
// R19 - Tx-empty and tx-idle requests merge; both receive sources merge.
`timescale 1ns/1ps
`include "ss_defs.svh"

module ss_sync_serial #(
    parameter int FIFO_DEPTH = 4
) (
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        rst_n,
    // Register bus
    input  wire logic [7:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    input  wire logic [3:0]  avs_byteenable,
    output logic      [31:0] avs_readdata,
    output logic             avs_waitrequest,
    // Baud clock tick from the rate generator, same clock domain
    input  wire logic        baud_tick,
    // Serial lines
    input  wire logic        sclk,
    input  wire logic        serial_data_in,
    output logic             serial_data_out,
    // Interrupt requests
    output logic             rx_irq,
    output logic             tx_irq,
    output logic             irq
);
    import ss_pkg::*;

    localparam int AW = $clog2(FIFO_DEPTH);
    localparam logic [AW:0] FIFO_FULL = (AW + 1)'(FIFO_DEPTH);

    // Bus decode
    logic        acc;
    logic        wr;
    logic        rd;
    logic        wr_ctrl;
    logic        wr_stat;
    logic        wr_ext;
    logic        wr_fifo;
    logic        wr_istat;
    logic        wr_imask;
    logic        data_rd;
    logic        data_wr;
    logic        clear_pulse;
    logic [31:0] rdata;

    // Software settings
    logic        receive_irq_enable;
    logic        transmit_irq_enable;
    logic        transmit_idle_irq_enable;
    logic        receive_enable;
    logic        transmit_enable;
    logic [2:0]  length_select;
    logic        output_force_high;
    logic        fifo_en;
    logic [AW:0] fifo_thr;
    logic [3:0]  istat;
    logic [3:0]  imask;
    logic [3:0]  events;
    logic [3:0]  len_bits;
    logic [8:0]  len_mask;

    // Link synchronisers
    logic [2:0]  sclk_s;
    logic [1:0]  sin_s;
    logic        sclk_rise;
    logic        sclk_fall;

    // Receive side
    logic [8:0]  rx_sr;
    logic [8:0]  rx_word;
    logic [3:0]  rx_cnt;
    logic        rx_done;
    logic [8:0]  receive_data_reg;
    logic        overrun_flag;
    logic        receive_full_flag;
    logic [8:0]  fifo_mem [FIFO_DEPTH];
    logic [AW-1:0] fifo_wp;
    logic [AW-1:0] fifo_rp;
    logic [AW:0] fifo_cnt;
    logic [AW:0] next_fifo_cnt;
    logic        push;
    logic        pop;
    logic        overrun;
    logic        load;
    logic        fifo_mode;
    logic        thr_hit;
    logic [3:0]  idle_cnt;
    logic        idle_run;
    logic        idle_hit;

    // Transmit side
    logic [8:0]  transmit_data_reg;
    logic        transmit_empty_flag;
    logic        transmit_idle_flag;
    logic        tx_busy;
    logic [8:0]  tx_sr;
    logic [3:0]  tx_cnt;
    logic        tx_start;
    logic        tx_accept;

    assign len_bits = ss_len_bits(length_select); // R11
    assign len_mask = ss_len_mask(length_select);

    assign acc      = (avs_read | avs_write) & ~avs_waitrequest;
    assign wr       = avs_write & acc;
    assign rd       = avs_read & acc;
    assign wr_ctrl  = wr & (avs_address == `SS_OFF_CTRL);
    assign wr_stat  = wr & (avs_address == `SS_OFF_STAT);
    assign wr_ext   = wr & (avs_address == `SS_OFF_EXT) & avs_byteenable[0];
    assign wr_fifo  = wr & (avs_address == `SS_OFF_FIFO) & avs_byteenable[0];
    assign wr_istat = wr & (avs_address == `SS_OFF_ISTAT) & avs_byteenable[0];
    assign wr_imask = wr & (avs_address == `SS_OFF_IMASK) & avs_byteenable[0];
    assign data_rd  = rd & (avs_address == `SS_OFF_DATA); // R15
    assign data_wr  = wr & (avs_address == `SS_OFF_DATA) & avs_byteenable[0];
    assign clear_pulse = wr_ctrl & avs_byteenable[1] & avs_writedata[`SS_CTL_CLEAR];

    // One wait cycle per access keeps the read mux off the bus path
    always_ff @(posedge clk)
    begin
        if (!rst_n)
            avs_waitrequest <= 1'b1;
        else if ((avs_read | avs_write) & avs_waitrequest)
            avs_waitrequest <= 1'b0;
        else
            avs_waitrequest <= 1'b1;
    end

    always_comb
    begin
        rdata = 32'h0000_0000;
        unique case (avs_address)
            `SS_OFF_CTRL:
            begin
                rdata[`SS_CTL_RIE]  = receive_irq_enable;
                rdata[`SS_CTL_TIE]  = transmit_irq_enable;
                rdata[`SS_CTL_TRANSMIT_IDLE_IRQ_ENABLE] = transmit_idle_irq_enable;
                rdata[`SS_CTL_RXE]  = receive_enable;
                rdata[`SS_CTL_TXE]  = transmit_enable;
            end
            `SS_OFF_DATA:
                rdata[8:0] = ((fifo_cnt != '0) ? fifo_mem[fifo_rp] : receive_data_reg)
                             & len_mask; // R12
            `SS_OFF_STAT:
            begin
                rdata[`SS_ST_ORE]  = overrun_flag; // R1
                rdata[`SS_ST_RECEIVE_FULL_FLAG] = receive_full_flag;
                rdata[`SS_ST_TRANSMIT_EMPTY_FLAG] = transmit_empty_flag;
                rdata[`SS_ST_TBI]  = transmit_idle_flag;
            end
            `SS_OFF_EXT:
                rdata[2:0] = length_select; // R10
            `SS_OFF_FIFO:
            begin
                rdata[`SS_FIFO_EN] = fifo_en;
                rdata[`SS_FIFO_THR +: AW + 1] = fifo_thr;
                rdata[`SS_FIFO_CNT +: AW + 1] = fifo_cnt;
            end
            `SS_OFF_ISTAT:
                rdata[3:0] = istat;
            `SS_OFF_IMASK:
                rdata[3:0] = imask;
            default:
                rdata = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n)
            avs_readdata <= 32'h0000_0000;
        else if (avs_read & avs_waitrequest)
            avs_readdata <= rdata;
    end

    // Control settings survive the programmable clear
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            receive_irq_enable       <= 1'b0;
            transmit_irq_enable      <= 1'b0;
            transmit_idle_irq_enable <= 1'b0;
            receive_enable           <= 1'b0;
            transmit_enable          <= 1'b0;
        end
        else if (wr_ctrl & avs_byteenable[1])
        begin
            receive_irq_enable       <= avs_writedata[`SS_CTL_RIE];
            transmit_irq_enable      <= avs_writedata[`SS_CTL_TIE];
            transmit_idle_irq_enable <= avs_writedata[`SS_CTL_TRANSMIT_IDLE_IRQ_ENABLE];
            receive_enable           <= avs_writedata[`SS_CTL_RXE];
            transmit_enable          <= avs_writedata[`SS_CTL_TXE];
        end
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            length_select     <= `SS_LEN_RST;
            output_force_high <= 1'b0;
        end
        else if (wr_ext)
        begin
            length_select     <= avs_writedata[2:0];
            output_force_high <= avs_writedata[`SS_EXT_FORCE];
        end
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            fifo_en  <= 1'b0;
            fifo_thr <= (AW + 1)'(1);
        end
        else if (overrun & fifo_en)
            fifo_en <= 1'b0; // R3
        else if (wr_fifo)
        begin
            fifo_en  <= avs_writedata[`SS_FIFO_EN];
            fifo_thr <= avs_writedata[`SS_FIFO_THR +: AW + 1];
        end
    end

    // Logic uses the second stage of each synchroniser, plus the third sclk_s stage for edges
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            sclk_s <= 3'h0;
            sin_s  <= 2'h0;
        end
        else
        begin
            sclk_s <= {sclk_s[1:0], sclk};
            sin_s  <= {sin_s[0], serial_data_in};
        end
    end

    assign sclk_rise = sclk_s[1] & ~sclk_s[2];
    assign sclk_fall = ~sclk_s[1] & sclk_s[2];

    always_comb
    begin
        rx_word = rx_sr;
        rx_word[rx_cnt] = sin_s[1];
    end

    assign rx_done = receive_enable & sclk_rise & ~clear_pulse
                     & (rx_cnt == len_bits - 4'h1);

    // Receive shifter, LSB first on the rising edge
    always_ff @(posedge clk)
    begin
        if (!rst_n || clear_pulse || !receive_enable) // R17 R18
        begin
            rx_sr  <= 9'h000;
            rx_cnt <= 4'h0;
        end
        else if (sclk_rise)
        begin
            if (rx_done)
            begin
                rx_sr  <= 9'h000;
                rx_cnt <= 4'h0;
            end
            else
            begin
                rx_sr  <= rx_word;
                rx_cnt <= rx_cnt + 4'h1;
            end
        end
    end

    assign fifo_mode = fifo_en | (fifo_cnt != '0);
    assign push    = rx_done & fifo_en & (fifo_cnt != FIFO_FULL);
    assign load    = rx_done & ~fifo_en & ~receive_full_flag; // R4
    assign overrun = rx_done & (fifo_en ? (fifo_cnt == FIFO_FULL)
                                        : receive_full_flag);
    assign pop     = data_rd & (fifo_cnt != '0);
    assign next_fifo_cnt = fifo_cnt + (AW + 1)'(push) - (AW + 1)'(pop);
    assign thr_hit = fifo_en & (next_fifo_cnt != '0) & (next_fifo_cnt >= fifo_thr); // R5

    always_ff @(posedge clk)
    begin
        if (!rst_n || clear_pulse)
        begin
            fifo_wp  <= '0;
            fifo_rp  <= '0;
            fifo_cnt <= '0;
        end
        else
        begin
            if (push)
            begin
                fifo_mem[fifo_wp] <= rx_word & len_mask;
                fifo_wp <= fifo_wp + AW'(1);
            end
            if (pop)
                fifo_rp <= fifo_rp + AW'(1);
            fifo_cnt <= next_fifo_cnt;
        end
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n)
            receive_data_reg <= `SS_RDR_RST;
        else if (load)
            receive_data_reg <= rx_word & len_mask; // R12
    end

    // Idle timeout runs only while words wait below the threshold
    assign idle_run = fifo_en & (fifo_cnt != '0) & (fifo_cnt < fifo_thr) & (rx_cnt == 4'h0);
    assign idle_hit = idle_run & baud_tick & (idle_cnt == `SS_IDLE_BAUDS - 4'h1);

    always_ff @(posedge clk)
    begin
        if (!rst_n || clear_pulse || !idle_run || data_rd || sclk_rise || idle_hit)
            idle_cnt <= 4'h0; // R6
        else if (baud_tick)
            idle_cnt <= idle_cnt + 4'h1;
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n || clear_pulse)
            receive_full_flag <= 1'b0; // R17
        else if (load || thr_hit || idle_hit) // R4 R5 R6
            receive_full_flag <= 1'b1;
        else if ((data_rd && !fifo_mode) || (fifo_mode && next_fifo_cnt == '0))
            receive_full_flag <= 1'b0;
    end

    // A new overrun in the clearing cycle wins over the clear
    always_ff @(posedge clk)
    begin
        if (!rst_n)
            overrun_flag <= 1'b0;
        else if (overrun)
            overrun_flag <= 1'b1; // R2
        else if (clear_pulse)
            overrun_flag <= 1'b0; // R17
        else if (wr_stat && avs_byteenable[1] && avs_writedata[`SS_ST_ERRCLR])
            overrun_flag <= 1'b0; // R1
    end

    // No transmit FIFO here, so the holding register alone gives room
    assign tx_accept = data_wr & transmit_empty_flag; // R14
    assign tx_start  = transmit_enable & ~transmit_empty_flag & ~tx_busy & ~clear_pulse; // R13

    always_ff @(posedge clk)
    begin
        if (!rst_n)
            transmit_data_reg <= `SS_TDR_RST;
        else if (tx_accept)
            transmit_data_reg <= {avs_byteenable[1] & avs_writedata[8], avs_writedata[7:0]}
                                 & len_mask; // R13
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n || clear_pulse)
            transmit_empty_flag <= 1'b1; // R8
        else if (tx_start)
            transmit_empty_flag <= 1'b1; // R7
        else if (tx_accept)
            transmit_empty_flag <= 1'b0; // R7
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n || clear_pulse)
            transmit_idle_flag <= 1'b1; // R17
        else if (tx_accept)
            transmit_idle_flag <= 1'b0; // R9
        else if (transmit_empty_flag && !tx_busy)
            transmit_idle_flag <= 1'b1; // R9
    end

    // Bits advance on the falling edge so each is stable for the rising sample
    always_ff @(posedge clk)
    begin
        if (!rst_n || clear_pulse || !transmit_enable) // R17 R18
        begin
            tx_busy <= 1'b0;
            tx_cnt  <= 4'h0;
            tx_sr   <= 9'h000;
        end
        else if (tx_start)
        begin
            tx_busy <= 1'b1;
            tx_cnt  <= 4'h0;
            tx_sr   <= transmit_data_reg;
        end
        else if (tx_busy && sclk_rise)
            tx_cnt <= tx_cnt + 4'h1;
        else if (tx_busy && sclk_fall && tx_cnt == len_bits)
            tx_busy <= 1'b0;
    end

    // The line holds its last bit between frames
    always_ff @(posedge clk)
    begin
        if (!rst_n)
            serial_data_out <= 1'b1;
        else if (!transmit_enable && output_force_high)
            serial_data_out <= 1'b1; // R10
        else if (tx_start)
            serial_data_out <= transmit_data_reg[0];
        else if (tx_busy && sclk_fall && tx_cnt < len_bits)
            serial_data_out <= tx_sr[tx_cnt];
    end

    assign events[`SS_EV_OVR]   = overrun;
    assign events[`SS_EV_RXW]   = load | push;
    assign events[`SS_EV_TXS]   = tx_start;
    assign events[`SS_EV_TIDLE] = ~transmit_idle_flag & transmit_empty_flag & ~tx_busy
                                  & ~tx_accept;

    // Sticky events: a set in the clearing cycle survives
    always_ff @(posedge clk)
    begin
        if (!rst_n)
            istat <= 4'h0;
        else if (wr_istat)
            istat <= (istat & ~avs_writedata[3:0]) | events;
        else
            istat <= istat | events;
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n)
            imask <= 4'h0;
        else if (wr_imask)
            imask <= avs_writedata[3:0];
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            rx_irq <= 1'b0;
            tx_irq <= 1'b0;
            irq    <= 1'b0;
        end
        else
        begin
            rx_irq <= receive_irq_enable & (receive_full_flag | overrun_flag); // R2 R4 R19
            tx_irq <= (transmit_irq_enable & transmit_empty_flag)
                      | (transmit_idle_irq_enable & transmit_idle_flag); // R8 R9 R19
            irq    <= |(istat & imask);
        end
    end

endmodule

/* File: bench/ss_sync_serial_asserts.sv */
// Concurrent checks on the ports of the serial channel
`timescale 1ns/1ps
`include "ss_defs.svh"
module ss_sync_serial_asserts #(
    parameter int FIFO_DEPTH = 4
) (
    // Clock and reset
    input wire logic        clk,
    input wire logic        rst_n,
    // Register bus
    input wire logic [7:0]  avs_address,
    input wire logic        avs_read,
    input wire logic        avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0]  avs_byteenable,
    input wire logic [31:0] avs_readdata,
    input wire logic        avs_waitrequest,
    // Serial side
    input wire logic        baud_tick,
    input wire logic        sclk,
    input wire logic        serial_data_in,
    input wire logic        serial_data_out,
    // Interrupts
    input wire logic        rx_irq,
    input wire logic        tx_irq,
    input wire logic        irq
);
    logic wr_done, rd_done, ctl_wr;

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);

    assign wr_done = avs_write && !avs_waitrequest;
    assign rd_done = avs_read && !avs_waitrequest;
    assign ctl_wr  = wr_done && avs_address == `SS_OFF_CTRL && avs_byteenable[1];

    a_reset_quiet: assert property (disable iff (1'b0) !rst_n |=> avs_waitrequest
        && serial_data_out && !rx_irq && !tx_irq && !irq) else $error("busy in reset");
    a_wait_one: assert property ((avs_read || avs_write) && avs_waitrequest
        |=> !avs_waitrequest ##1 avs_waitrequest) else $error("late answer");
    a_wait_cause: assert property (!avs_waitrequest |-> $past(avs_read || avs_write))
        else $error("stray answer");
    a_unmapped_zero: assert property (rd_done && avs_address == 8'h00 |-> avs_readdata == 32'h0)
        else $error("unmapped read not zero");
    a_errclr_reads0: assert property (rd_done && avs_address == `SS_OFF_STAT
        |-> !avs_readdata[`SS_ST_ERRCLR]) else $error("error clear reads one");
    a_force_reads0: assert property (rd_done && avs_address == `SS_OFF_EXT
        |-> !avs_readdata[`SS_EXT_FORCE]) else $error("force bit reads one");
    a_data_width: assert property (rd_done && avs_address == `SS_OFF_DATA
        |-> avs_readdata[31:9] == 23'h0) else $error("data above bit 8");
    a_clear_txirq: assert property (ctl_wr && avs_writedata[`SS_CTL_CLEAR]
        && avs_writedata[`SS_CTL_TIE] |-> ##[1:3] tx_irq) else $error("no tx irq after clear");
    a_rie_off: assert property (ctl_wr && !avs_writedata[`SS_CTL_RIE]
        |-> ##[1:2] !rx_irq) else $error("rx irq while disabled");
    a_tx_src_off: assert property (ctl_wr && !avs_writedata[`SS_CTL_TIE]
        && !avs_writedata[`SS_CTL_TRANSMIT_IDLE_IRQ_ENABLE] |-> ##[1:2] !tx_irq) else $error("tx irq while disabled");
    a_mask_off: assert property (wr_done && avs_address == `SS_OFF_IMASK
        && avs_byteenable[0] && avs_writedata[3:0] == 4'h0 |-> ##[1:2] !irq)
        else $error("irq while masked");

    cover property (wr_done && avs_address == `SS_OFF_DATA);
    cover property ($rose(rx_irq));
    cover property ($rose(tx_irq));
    cover property ($rose(irq));
endmodule

bind ss_sync_serial ss_sync_serial_asserts #(.FIFO_DEPTH(FIFO_DEPTH)) i_chk (.*);

/* File: bench/ss_serial_partner.sv */
// Far-side serial device that clocks frames
`timescale 1ns/1ps
module ss_serial_partner (
    // Serial lines
    output logic      sclk,
    output logic      serial_data_in,
    input  wire logic serial_data_out
);
    initial
    begin
        sclk = 1'b0;
        serial_data_in = 1'b0;
    end

    // Clock stands still between frames; 160 ns period, LSB first
    task automatic exchange(input logic [8:0] din, input int n, output logic [8:0] dout);
        dout = 9'h000;
        serial_data_in = din[0];
        #37;
        for (int i = 0; i < n; i++)
        begin
            sclk = 1'b1;
            dout[i] = serial_data_out;
            #80;
            sclk = 1'b0;
            if (i < n - 1)
                serial_data_in = din[i + 1];
            #80;
        end
        // Inverted on release so a stale bit cannot pass
        serial_data_in = ~serial_data_in;
    endtask
endmodule

/* File: bench/tb_top.sv */
// Self-checking bench of the serial channel
`timescale 1ns/1ps
`include "ss_defs.svh"
module tb_top;
    logic        clk, rst_n, avs_read, avs_write, avs_waitrequest, baud_tick;
    logic        sclk, serial_data_in, serial_data_out, rx_irq, tx_irq, irq;
    logic [7:0]  avs_address;
    logic [31:0] avs_writedata;
    logic [3:0]  avs_byteenable;
    logic [31:0] avs_readdata;
    int          n_mismatch, checks_done;
    logic [31:0] seed, rd, r32;
    logic [8:0]  tx, rx, cap, m;
    logic [8:0]  wq [3];

    ss_sync_serial #(.FIFO_DEPTH(4)) i_dut (.*);
    ss_serial_partner i_partner (.*);

    always #10 clk = ~clk;

    function logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    function logic [8:0] len_mask(input int c);
        return 9'((10'h001 << ((c == 0) ? 8 : (c == 4) ? 9 : c + 4)) - 10'h001);
    endfunction

    task give_verdict();
        $display("checks %0d, mismatches %0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        checks_done++;
        if (g !== e)
        begin
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
            n_mismatch++;
        end
    endtask

    // Full-word accesses keep bit 8 of the data register reachable
    task bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int i;
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= wr;
        avs_read <= !wr;
        i = 0;
        do
        begin
            @(posedge clk);
            i++;
        end while (avs_waitrequest !== 1'b0 && i < 50);
        rd = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
        @(posedge clk);
        if (i >= 50)
        begin
            n_mismatch++;
            give_verdict();
        end
    endtask

    task stat_chk(input string nm, input logic [3:0] e);
        bus(1'b0, `SS_OFF_STAT, 32'h0);
        chk(nm, 32'(e), 32'(rd[11:8]));
    endtask

    // Registered outputs need two edges to show
    task automatic pchk(input string nm, input logic e, ref logic g);
        repeat (2) @(posedge clk);
        chk(nm, 32'(e), 32'(g));
    endtask

    task tick(input int n);
        repeat (n)
        begin
            repeat (xs() % 3 + 1) @(posedge clk);
            baud_tick <= 1'b1;
            @(posedge clk);
            baud_tick <= 1'b0;
        end
    endtask

    task frame(input logic [8:0] d, input int n);
        i_partner.exchange(d, n, cap);
        @(posedge clk);
    endtask

    initial
    begin
        #1_500_000;
        n_mismatch++;
        give_verdict();
    end

    initial
    begin
        clk = 1'b0;
        rst_n = 1'b0;
        avs_address = 8'h00;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_writedata = 32'h0;
        avs_byteenable = 4'hf;
        baud_tick = 1'b0;
        seed = 32'd87;
        n_mismatch = 0;
        checks_done = 0;
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        stat_chk("reset status", 4'h3);
        bus(1'b0, `SS_OFF_DATA, 32'h0);
        chk("reset data", 32'h0, rd);
        bus(1'b0, 8'h00, 32'h0);
        chk("unmapped read", 32'h0, rd);
        $display("test reset done");
        for (int c = 0; c < 5; c++)
        begin
            m = len_mask(c);
            r32 = xs();
            tx = r32[8:0];
            rx = r32[24:16];
            if (c == 4)
                tx[8] = 1'b0;
            bus(1'b1, `SS_OFF_EXT, 32'(c));
            bus(1'b1, `SS_OFF_CTRL, 32'h0300);
            bus(1'b1, `SS_OFF_DATA, 32'(tx));
            frame(rx, $countones(m));
            chk("tx frame", 32'(tx & m), 32'(cap));
            stat_chk("rx full", 4'h7);
            bus(1'b0, `SS_OFF_DATA, 32'h0);
            chk("rx data", 32'(rx & m), rd);
            stat_chk("rx read", 4'h3);
        end
        bus(1'b1, `SS_OFF_CTRL, 32'h0200);
        chk("line holds", 32'h0, 32'(serial_data_out));
        bus(1'b1, `SS_OFF_EXT, 32'h84);
        pchk("force high", 1'b1, serial_data_out);
        bus(1'b1, `SS_OFF_EXT, 32'h0);
        $display("test lengths done");
        bus(1'b1, `SS_OFF_CTRL, 32'h1200);
        frame(9'h0c3, 8);
        frame(9'h03c, 8);
        stat_chk("overrun", 4'hf);
        pchk("rx irq", 1'b1, rx_irq);
        bus(1'b1, `SS_OFF_STAT, 32'h0);
        stat_chk("overrun kept", 4'hf);
        bus(1'b1, `SS_OFF_STAT, 32'h8000);
        stat_chk("overrun cleared", 4'h7);
        bus(1'b0, `SS_OFF_DATA, 32'h0);
        pchk("rx irq off", 1'b0, rx_irq);
        $display("test overrun done");
        bus(1'b1, `SS_OFF_CTRL, 32'h0200);
        bus(1'b1, `SS_OFF_DATA, 32'h0a5);
        stat_chk("tx pending", 4'h0);
        bus(1'b1, `SS_OFF_CTRL, 32'h8a00);
        stat_chk("after clear", 4'h3);
        pchk("tx irq", 1'b1, tx_irq);
        $display("test clear done");
        bus(1'b1, `SS_OFF_CTRL, 32'h0100);
        for (int k = 0; k < 3; k++)
        begin
            r32 = xs();
            wq[k] = {1'b0, r32[7:0]};
            bus(1'b1, `SS_OFF_DATA, 32'(wq[k]));
        end
        stat_chk("tx busy", 4'h0);
        frame(9'h000, 8);
        chk("first word", 32'(wq[0]), 32'(cap));
        frame(9'h000, 8);
        chk("second word", 32'(wq[1]), 32'(cap));
        stat_chk("tx idle", 4'h3);
        $display("test refused write done");
        bus(1'b1, `SS_OFF_CTRL, 32'h0200);
        bus(1'b1, `SS_OFF_FIFO, 32'h0201);
        r32 = xs();
        rx = r32[8:0];
        frame(rx, 8);
        stat_chk("below threshold", 4'h3);
        tick(7);
        stat_chk("seven ticks", 4'h3);
        tick(1);
        stat_chk("eight ticks", 4'h7);
        bus(1'b0, `SS_OFF_DATA, 32'h0);
        chk("fifo head", 32'(rx & 9'h0ff), rd);
        stat_chk("fifo empty", 4'h3);
        $display("test idle timeout done");
        bus(1'b1, `SS_OFF_FIFO, 32'h0);
        bus(1'b1, `SS_OFF_IMASK, 32'h0);
        pchk("irq masked", 1'b0, irq);
        bus(1'b1, `SS_OFF_ISTAT, 32'hf);
        bus(1'b1, `SS_OFF_IMASK, 32'h2);
        frame(9'h05a, 8);
        pchk("irq raised", 1'b1, irq);
        bus(1'b0, `SS_OFF_ISTAT, 32'h0);
        chk("word event", 32'h2, rd & 32'h2);
        bus(1'b1, `SS_OFF_ISTAT, 32'h2);
        pchk("irq cleared", 1'b0, irq);
        $display("test interrupts done");
        give_verdict();
    end
endmodule
